//--- core/rpc_checker.sv
// region protection checker top: configuration, match, priority, verdict
module rpc_checker
#(
  parameter int         NUM_REGIONS = 16,
  parameter bit         HAS_PROT    = 1'b1,
  parameter logic [4:0] MIN_SIZE    = 5'h04
)
(
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        CFG_WRITE,
  input  wire logic [1:0]  CFG_REG,
  input  wire logic [31:0] CFG_WDATA,
  output      logic [31:0] CFG_RDATA,
  input  wire logic        PROTECTION_ENABLE,
  input  wire logic        BACKGROUND_REGION_ENABLE,
  input  wire logic        HIGH_VECTORS_ENABLE,
  input  wire logic        ICACHE_ENABLE,
  input  wire logic        DCACHE_ENABLE,
  input  wire logic        REQ_VALID,
  input  wire logic [31:0] REQ_ADDR,
  input  wire logic        REQ_FETCH,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_PRIV,
  output      logic        RSP_VALID,
  output      logic        RSP_ALLOW,
  output      logic        RSP_PREFETCH_ABORT,
  output      logic        RSP_DATA_ABORT,
  output      logic        RSP_BACKGROUND_FAULT,
  output      logic [1:0]  RSP_MEM_TYPE,
  output      logic [1:0]  RSP_CACHE_POLICY,
  output      logic        RSP_SHARED,
  output      logic [3:0]  RSP_REGION,
  output      logic        RSP_REGION_HIT,
  output      logic        NO_REGION_LOCK
);
  localparam int NR = HAS_PROT ? NUM_REGIONS : 1;

  logic [3:0]  sel_q;
  logic [3:0]  sel_d;
  logic [31:0] base_v [NR];
  logic [31:0] size_v [NR];
  logic [31:0] acc_v  [NR];
  logic [NR-1:0] hit_v;
  logic [NR-1:0] defined_v;
  logic        any_defined;
  logic        lock_q;
  logic        lock_d;

  // write strobes of the four configuration registers, decoded from CFG_WRITE and CFG_REG
  logic        wr_sel;
  logic        wr_base;
  logic        wr_size;
  logic        wr_acc;

  assign wr_sel  = CFG_WRITE && (CFG_REG == 2'(rpc_pkg::WR_SELECT));
  assign wr_base = CFG_WRITE && (CFG_REG == 2'(rpc_pkg::WR_BASE));
  assign wr_size = CFG_WRITE && (CFG_REG == 2'(rpc_pkg::WR_SIZE));
  assign wr_acc  = CFG_WRITE && (CFG_REG == 2'(rpc_pkg::WR_ACCESS));
  assign sel_d   = wr_sel ? CFG_WDATA[rpc_pkg::SEL_MSB:rpc_pkg::SEL_LSB] : sel_q;

  genvar g;
  generate
    for (g = 0; g < NR; g++)
    begin : g_reg
      logic sel_hit;
      assign sel_hit = (sel_q == 4'(g)) && HAS_PROT;
      rpc_region #(.MIN_SIZE(MIN_SIZE)) u_region (
        .clk     (CLOCK),
        .rst_n   (RESETN),
        .wr_base (wr_base && sel_hit),
        .wr_size (wr_size && sel_hit),
        .wr_acc  (wr_acc && sel_hit),
        .wdata   (CFG_WDATA),
        .addr    (REQ_ADDR),
        .base_q  (base_v[g]),
        .size_q  (size_v[g]),
        .acc_q   (acc_v[g]),
        .hit     (hit_v[g])
      );
      assign defined_v[g] = size_v[g][rpc_pkg::ENABLE_BIT];
    end
  endgenerate

  assign any_defined = |defined_v;

  // highest numbered hit wins, permissions play no part in the choice
  logic [3:0] win_idx;
  logic       win_hit;
  always_comb
  begin
    win_idx = 4'h0;
    win_hit = 1'b0;
    for (int i = 0; i < NR; i++)
    begin
      if (hit_v[i] && HAS_PROT)
      begin
        win_idx = 4'(i);
        win_hit = 1'b1;
      end
    end
  end

  logic [31:0] win_acc;
  logic [2:0]  perm;
  logic        reg_xn;
  logic [2:0]  tex;
  logic        cb_c;
  logic        cb_b;
  assign win_acc = acc_v[win_idx[$clog2(NR > 1 ? NR : 2)-1:0]];
  assign perm    = win_acc[rpc_pkg::PERM_MSB:rpc_pkg::PERM_LSB];
  assign reg_xn  = win_acc[rpc_pkg::XN_BIT];
  assign tex     = win_acc[rpc_pkg::TEX_MSB:rpc_pkg::TEX_LSB];
  assign cb_c    = win_acc[rpc_pkg::CACHE_BIT];
  assign cb_b    = win_acc[rpc_pkg::BUFF_BIT];

  // permission table: reads and writes, privileged and user
  logic rd_ok;
  logic wr_ok;
  always_comb
  begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (perm)
      rpc_pkg::PERM_PRIV_RW:
      begin
        rd_ok = REQ_PRIV;
        wr_ok = REQ_PRIV;
      end
      rpc_pkg::PERM_USER_RO:
      begin
        rd_ok = 1'b1;
        wr_ok = REQ_PRIV;
      end
      rpc_pkg::PERM_FULL:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      rpc_pkg::PERM_PRIV_RO: rd_ok = REQ_PRIV;
      rpc_pkg::PERM_RO:      rd_ok = 1'b1;
      default:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // region memory type from type extension and cache bits
  logic [1:0] reg_mtype;
  logic [1:0] reg_cpol;
  always_comb
  begin
    reg_mtype = 2'(rpc_pkg::MT_NORMAL);
    reg_cpol  = 2'(rpc_pkg::CP_NONCACHE);
    if (tex[2])
      reg_cpol = (cb_c && cb_b) ? 2'(rpc_pkg::CP_WBACK)
               : cb_c ? 2'(rpc_pkg::CP_WTHRU) : 2'(rpc_pkg::CP_NONCACHE);
    else
      case ({tex[1:0], cb_c, cb_b})
        4'h0:    reg_mtype = 2'(rpc_pkg::MT_STRONG);
        4'h1:    reg_mtype = 2'(rpc_pkg::MT_DEVICE);
        4'h2:    reg_cpol  = 2'(rpc_pkg::CP_WTHRU);
        4'h3:    reg_cpol  = 2'(rpc_pkg::CP_WBACK);
        4'h8:    reg_mtype = 2'(rpc_pkg::MT_DEVICE);
        default: reg_cpol  = 2'(rpc_pkg::CP_NONCACHE);
      endcase
  end

  logic       def_xn;
  logic [1:0] def_mtype;
  logic [1:0] def_cpol;
  logic       def_shared;
  rpc_defmap u_defmap (
    .addr      (REQ_ADDR),
    .fetch     (REQ_FETCH),
    .hivec     (HIGH_VECTORS_ENABLE),
    .icache_on (ICACHE_ENABLE),
    .dcache_on (DCACHE_ENABLE),
    .xn        (def_xn),
    .mtype     (def_mtype),
    .cpol      (def_cpol),
    .shared    (def_shared)
  );

  // verdict: combinational from the request inputs and registered region state, one cycle latency
  logic prot_on;
  logic use_def;
  logic bg_fault;
  logic perm_ok;
  logic allow;
  assign prot_on  = PROTECTION_ENABLE && HAS_PROT;
  assign use_def  = !prot_on || (!win_hit && BACKGROUND_REGION_ENABLE && REQ_PRIV);
  assign bg_fault = prot_on && !win_hit && !use_def;
  assign perm_ok  = REQ_WRITE ? wr_ok : rd_ok;
  assign allow    = !lock_q && (use_def ? !(REQ_FETCH && def_xn)
                  : (win_hit && perm_ok && !(REQ_FETCH && (reg_xn || !rd_ok))));

  // enabling with nothing defined leaves the checker refusing all until reset
  assign lock_d = lock_q || (prot_on && !any_defined);

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      sel_q                <= rpc_pkg::SEL_RESET;
      lock_q               <= 1'b0;
      RSP_VALID            <= 1'b0;
      RSP_ALLOW            <= 1'b0;
      RSP_PREFETCH_ABORT   <= 1'b0;
      RSP_DATA_ABORT       <= 1'b0;
      RSP_BACKGROUND_FAULT <= 1'b0;
      RSP_MEM_TYPE         <= 2'(rpc_pkg::MT_STRONG);
      RSP_CACHE_POLICY     <= 2'(rpc_pkg::CP_NONCACHE);
      RSP_SHARED           <= 1'b0;
      RSP_REGION           <= 4'h0;
      RSP_REGION_HIT       <= 1'b0;
      CFG_RDATA            <= 32'h00000000;
      NO_REGION_LOCK       <= 1'b0;
    end
    else
    begin
      sel_q                <= sel_d;
      lock_q               <= lock_d;
      NO_REGION_LOCK       <= lock_d;
      RSP_VALID            <= REQ_VALID;
      RSP_ALLOW            <= REQ_VALID && allow;
      RSP_PREFETCH_ABORT   <= REQ_VALID && !allow && REQ_FETCH;
      RSP_DATA_ABORT       <= REQ_VALID && !allow && !REQ_FETCH;
      RSP_BACKGROUND_FAULT <= REQ_VALID && bg_fault;
      RSP_MEM_TYPE         <= use_def ? def_mtype : reg_mtype;
      RSP_CACHE_POLICY     <= use_def ? def_cpol : reg_cpol;
      RSP_SHARED           <= use_def ? def_shared
                            : (win_acc[rpc_pkg::SHARE_BIT] || reg_mtype != 2'(rpc_pkg::MT_NORMAL));
      RSP_REGION           <= win_idx;
      RSP_REGION_HIT       <= win_hit && !use_def;
      case (CFG_REG)
        2'(rpc_pkg::WR_SELECT): CFG_RDATA <= {28'h0000000, sel_q};
        2'(rpc_pkg::WR_BASE):   CFG_RDATA <= base_v[sel_q[$clog2(NR > 1 ? NR : 2)-1:0]];
        2'(rpc_pkg::WR_SIZE):   CFG_RDATA <= size_v[sel_q[$clog2(NR > 1 ? NR : 2)-1:0]];
        default:                CFG_RDATA <= acc_v[sel_q[$clog2(NR > 1 ? NR : 2)-1:0]];
      endcase
    end
  end
endmodule : rpc_checker

//--- core/rpc_pkg.sv
// shared constants and types of the region protection checker
package rpc_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          SEL_LSB         = 0;
  localparam int          SEL_MSB         = 3;
  localparam int          BASE_LSB        = 5;
  localparam int          BASE_MSB        = 31;
  localparam int          SIZE_LSB        = 1;
  localparam int          SIZE_MSB        = 5;
  localparam int          ENABLE_BIT      = 0;
  localparam int          SUBDIS_LSB      = 8;
  localparam int          SUBDIS_MSB      = 15;
  localparam int          XN_BIT          = 12;
  localparam int          PERM_LSB        = 8;
  localparam int          PERM_MSB        = 10;
  localparam int          TEX_LSB         = 3;
  localparam int          TEX_MSB         = 5;
  localparam int          SHARE_BIT       = 2;
  localparam int          CACHE_BIT       = 1;
  localparam int          BUFF_BIT        = 0;
  localparam logic [4:0]  SIZE_MIN_SMALL  = 5'h04;
  localparam logic [4:0]  SIZE_MIN_LARGE  = 5'h07;
  localparam logic [4:0]  SIZE_SUB_MIN    = 5'h07;
  localparam logic [4:0]  SIZE_MAX        = 5'h1f;
  localparam logic [31:0] SIZE_RESET      = 32'h00000000;
  localparam logic [31:0] BASE_RESET      = 32'h00000000;
  localparam logic [31:0] ACC_RESET       = 32'h00000000;
  localparam logic [3:0]  SEL_RESET       = 4'h0;
  localparam logic [3:0]  HIGH_AREA       = 4'hf;
  localparam logic [2:0]  PERM_NONE       = 3'h0;
  localparam logic [2:0]  PERM_PRIV_RW    = 3'h1;
  localparam logic [2:0]  PERM_USER_RO    = 3'h2;
  localparam logic [2:0]  PERM_FULL       = 3'h3;
  localparam logic [2:0]  PERM_PRIV_RO    = 3'h5;
  localparam logic [2:0]  PERM_RO         = 3'h6;

  typedef enum logic [1:0] {
    MT_STRONG,
    MT_DEVICE,
    MT_NORMAL
  } rpc_mtype_t;

  typedef enum logic [1:0] {
    CP_NONCACHE,
    CP_WTHRU,
    CP_WBACK
  } rpc_cpol_t;

  typedef enum logic [1:0] {
    WR_SELECT,
    WR_BASE,
    WR_SIZE,
    WR_ACCESS
  } rpc_wsel_t;
endpackage : rpc_pkg

//--- core/rpc_region.sv
// one protection region: stored settings and address match
module rpc_region
  import rpc_pkg::*;
#(
  parameter logic [4:0] MIN_SIZE = 5'h04
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_base,
  input  wire logic        wr_size,
  input  wire logic        wr_acc,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] addr,
  output      logic [31:0] base_q,
  output      logic [31:0] size_q,
  output      logic [31:0] acc_q,
  output      logic        hit
);
  logic [31:0] mask;
  logic [4:0]  sz;
  logic        size_ok;
  logic [2:0]  sub_idx;
  logic        sub_on;
  logic        in_range;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      base_q <= rpc_pkg::BASE_RESET;
      size_q <= rpc_pkg::SIZE_RESET;
      acc_q  <= rpc_pkg::ACC_RESET;
    end
    else
    begin
      if (wr_base)
        base_q <= {wdata[rpc_pkg::BASE_MSB:rpc_pkg::BASE_LSB], 5'h00};
      if (wr_size)
        size_q <= wdata;
      if (wr_acc)
        acc_q <= wdata;
    end
  end

  assign sz      = size_q[rpc_pkg::SIZE_MSB:rpc_pkg::SIZE_LSB];
  // region spans 2^(sz+1) bytes; out-of-range codes never match
  assign size_ok = (sz >= MIN_SIZE) && (sz <= rpc_pkg::SIZE_MAX);
  assign mask    = (sz == rpc_pkg::SIZE_MAX) ? 32'h00000000
                 : (32'hffffffff << (sz + 5'h01));
  // base bits below size are assumed zero by software, masked anyway
  assign in_range = ((addr & mask) == (base_q & mask));
  // sub-region index is the top three address bits inside the region
  assign sub_idx = 3'((addr >> (sz - 5'h02)) & 32'h7);
  assign sub_on  = (sz < rpc_pkg::SIZE_SUB_MIN) ? 1'b1
                 : !size_q[rpc_pkg::SUBDIS_LSB + 32'(sub_idx)];
  assign hit = size_q[rpc_pkg::ENABLE_BIT] && size_ok && in_range && sub_on;
endmodule : rpc_region

//--- core/rpc_defmap.sv
// fixed default memory map used when protection is off or as background
module rpc_defmap
  import rpc_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic        fetch,
  input  wire logic        hivec,
  input  wire logic        icache_on,
  input  wire logic        dcache_on,
  output      logic        xn,
  output      logic [1:0]  mtype,
  output      logic [1:0]  cpol,
  output      logic        shared
);
  logic [3:0] top;
  logic       normal_area;
  logic       cach_area;

  assign top         = addr[31:28];
  // low half normal cacheable, upper half device, top area special
  assign normal_area = !addr[31] || (top == rpc_pkg::HIGH_AREA);
  assign cach_area   = !addr[31];
  assign xn     = fetch ? ((top == rpc_pkg::HIGH_AREA) ? !hivec : addr[31])
                        : 1'b0;
  assign mtype  = normal_area ? 2'(rpc_pkg::MT_NORMAL) : 2'(rpc_pkg::MT_DEVICE);
  assign cpol   = !cach_area ? 2'(rpc_pkg::CP_NONCACHE)
                : fetch ? (icache_on ? 2'(rpc_pkg::CP_WTHRU) : 2'(rpc_pkg::CP_NONCACHE))
                : (dcache_on ? 2'(rpc_pkg::CP_WBACK) : 2'(rpc_pkg::CP_NONCACHE));
  assign shared = fetch ? 1'b0 : (!normal_area || (cach_area && !dcache_on));
endmodule : rpc_defmap

//--- verification/rpc_checker_asserts.sv
// concurrent checks on the ports of the region protection checker
module rpc_checker_asserts
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        PROTECTION_ENABLE,
  input wire logic        HIGH_VECTORS_ENABLE,
  input wire logic        ICACHE_ENABLE,
  input wire logic        REQ_VALID,
  input wire logic [31:0] REQ_ADDR,
  input wire logic        REQ_FETCH,
  input wire logic        RSP_VALID,
  input wire logic        RSP_ALLOW,
  input wire logic        RSP_PREFETCH_ABORT,
  input wire logic        RSP_DATA_ABORT,
  input wire logic        RSP_BACKGROUND_FAULT,
  input wire logic [1:0]  RSP_CACHE_POLICY,
  input wire logic        RSP_REGION_HIT,
  input wire logic        NO_REGION_LOCK
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  // default-map requests; a locked unit refuses everything, so those are left out
  sequence off_s;
    REQ_VALID && !PROTECTION_ENABLE && !NO_REGION_LOCK;
  endsequence
  sequence off_data_s;
    off_s ##0 !REQ_FETCH;
  endsequence
  sequence hi_fetch_s;
    off_s ##0 REQ_FETCH && REQ_ADDR[31:28] == 4'hf;
  endsequence
  sequence cold_fetch_s;
    off_s ##0 REQ_FETCH && !ICACHE_ENABLE && !REQ_ADDR[31];
  endsequence
  rsp_follows_a: assert property ($past(RESETN) |-> RSP_VALID == $past(REQ_VALID))
    else $error("response valid not one cycle after request");
  reset_quiet_a: assert property (!$past(RESETN) |-> !RSP_VALID && !RSP_ALLOW && !NO_REGION_LOCK)
    else $error("outputs not quiet after reset");
  prefetch_kind_a: assert property (RSP_PREFETCH_ABORT |-> $past(REQ_FETCH) && !RSP_ALLOW)
    else $error("prefetch abort on a data access or with allow");
  data_kind_a: assert property (RSP_DATA_ABORT |-> !$past(REQ_FETCH) && !RSP_ALLOW)
    else $error("data abort on a fetch or with allow");
  lock_sticky_a: assert property (NO_REGION_LOCK |=> NO_REGION_LOCK)
    else $error("lock cleared without reset");
  lock_refuse_a: assert property (NO_REGION_LOCK && $past(NO_REGION_LOCK) && RSP_VALID |-> !RSP_ALLOW)
    else $error("access allowed while locked");
  off_data_a: assert property (off_data_s |=> RSP_ALLOW)
    else $error("data access refused with protection off");
  hivec_xn_a: assert property (hi_fetch_s |=> RSP_PREFETCH_ABORT == !$past(HIGH_VECTORS_ENABLE))
    else $error("top area fetch verdict wrong for high vectors");
  icache_off_a: assert property (cold_fetch_s |=> RSP_CACHE_POLICY == 2'h0)
    else $error("fetch cacheable with instruction cache off");
  bg_fault_a: assert property (RSP_BACKGROUND_FAULT |-> !RSP_ALLOW && !RSP_REGION_HIT)
    else $error("background fault with allow or region hit");
endmodule : rpc_checker_asserts

bind rpc_checker rpc_checker_asserts i_rpc_checker_asserts (
  .CLOCK(CLOCK), .RESETN(RESETN), .PROTECTION_ENABLE(PROTECTION_ENABLE),
  .HIGH_VECTORS_ENABLE(HIGH_VECTORS_ENABLE), .ICACHE_ENABLE(ICACHE_ENABLE),
  .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_FETCH(REQ_FETCH), .RSP_VALID(RSP_VALID),
  .RSP_ALLOW(RSP_ALLOW), .RSP_PREFETCH_ABORT(RSP_PREFETCH_ABORT),
  .RSP_DATA_ABORT(RSP_DATA_ABORT), .RSP_BACKGROUND_FAULT(RSP_BACKGROUND_FAULT),
  .RSP_CACHE_POLICY(RSP_CACHE_POLICY), .RSP_REGION_HIT(RSP_REGION_HIT),
  .NO_REGION_LOCK(NO_REGION_LOCK));

//--- verification/rpc_core_model.sv
// requester model of the core fetch and load/store side, one access per cycle
module rpc_core_model
(
  output logic        req_valid,
  output logic [31:0] req_addr,
  output logic        req_fetch,
  output logic        req_write,
  output logic        req_priv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {req_valid, req_addr, req_fetch, req_write, req_priv} = 36'h0;
  end
  // called just after a falling edge; held until the next call
  task automatic put(input logic [31:0] a, input logic f, input logic w, input logic p);
    {req_valid, req_addr, req_fetch, req_write, req_priv} = {1'b1, a, f, w, p};
  endtask : put
  // valid drops, address and fetch are inverted; write and privilege keep the old value
  task automatic idle();
    {req_valid, req_addr, req_fetch} = {1'b0, ~req_addr, ~req_fetch};
  endtask : idle
endmodule : rpc_core_model

//--- verification/rpc_checker_tb.sv
// self-checking bench of the region protection checker
module rpc_checker_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          NREG = 12;
  localparam logic [31:0] BASE_T [3] = '{32'h20000000, 32'h20004000, 32'h40000000};
  localparam logic [31:0] MASK_T [3] = '{32'h0000ffff, 32'h0000001f, 32'h000000ff};
  logic        clock, resetn, cfg_write, pe, bge, hve, ice, dce;
  logic [1:0]  cfg_reg;
  logic [31:0] cfg_wdata, r1, r2;
  wire  [31:0] cfg_rdata, req_addr;
  wire         req_valid, req_fetch, req_write, req_priv;
  wire         rsp_valid, allow, pab, dab, bgf, shared, hit, lock;
  wire  [1:0]  mtype, cpol;
  wire  [3:0]  region;
  int          err_count, n_compared, seed, i, k;
  logic [31:0] rb [16];
  logic [4:0]  rs [16];
  logic [7:0]  rd [16];
  logic [2:0]  rp [16];
  logic [3:0]  ra [16];
  logic        re [16];
  logic        rx [16];

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  rpc_checker #(.NUM_REGIONS(NREG), .HAS_PROT(1'b1), .MIN_SIZE(5'h04)) i_rpc_checker (
    .CLOCK(clock), .RESETN(resetn), .CFG_WRITE(cfg_write), .CFG_REG(cfg_reg),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .PROTECTION_ENABLE(pe),
    .BACKGROUND_REGION_ENABLE(bge), .HIGH_VECTORS_ENABLE(hve), .ICACHE_ENABLE(ice),
    .DCACHE_ENABLE(dce), .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_FETCH(req_fetch),
    .REQ_WRITE(req_write), .REQ_PRIV(req_priv), .RSP_VALID(rsp_valid), .RSP_ALLOW(allow),
    .RSP_PREFETCH_ABORT(pab), .RSP_DATA_ABORT(dab), .RSP_BACKGROUND_FAULT(bgf),
    .RSP_MEM_TYPE(mtype), .RSP_CACHE_POLICY(cpol), .RSP_SHARED(shared), .RSP_REGION(region),
    .RSP_REGION_HIT(hit), .NO_REGION_LOCK(lock));

  rpc_core_model i_rpc_core_model (.req_valid(req_valid), .req_addr(req_addr),
    .req_fetch(req_fetch), .req_write(req_write), .req_priv(req_priv));

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  function automatic logic perm_ok(input logic [2:0] c, input logic p, input logic w);
    case (c)
      3'h1: return p;
      3'h2: return p || !w;
      3'h3: return 1'b1;
      3'h5: return p && !w;
      3'h6: return !w;
      default: return 1'b0;
    endcase
  endfunction : perm_ok

  // {valid, hit, region, allow, prefetch abort, data abort, background fault}
  function automatic logic [9:0] expect_rsp(input logic [31:0] a, input logic f,
                                            input logic w, input logic p);
    logic [63:0] lo;
    logic        ok;
    for (int r = 15; r >= 0; r--)
    begin
      // six-bit sum so the whole-space code 5'h1f does not wrap to a zero shift
      lo = (64'h1 << (rs[r] + 6'h01)) - 64'h1;
      if (pe && re[r] && ((a ^ rb[r]) & ~lo[31:0]) == 32'h0
          && !(rs[r] >= 5'h07 && rd[r][3'(a >> (rs[r] - 5'h2))]))
      begin
        ok = !(f && rx[r]) && perm_ok(rp[r], p, w && !f);
        return {2'h3, 4'(r), ok, !ok && f, !ok && !f, 1'b0};
      end
    end
    if (pe && !(bge && p))
      return {6'h20, 1'b0, f, !f, 1'b1};
    ok = !f || !a[31] || (a[31:28] == 4'hf && hve);
    return {6'h20, ok, !ok, 2'h0};
  endfunction : expect_rsp

  task automatic acc(input logic [31:0] a, input logic f, input logic w, input logic p);
    logic [9:0] e;
    e = expect_rsp(a, f, w, p);
    i_rpc_core_model.put(a, f, w, p);
    @(negedge clock);
    check({rsp_valid, hit, hit ? region : 4'h0, allow, pab, dab, bgf}, e, "verdict");
    if (e[8])
      check({mtype, cpol}, ra[e[7:4]], "attributes");
    if (!pe && !a[31])
      check({cpol, shared && !f}, f ? {2'(ice), 1'b0} : {dce, 1'b0, !dce}, "default");
  endtask : acc

  // selection, base, size and access written back to back with the strobe held
  task automatic prog(input int r, input logic [31:0] b, input logic [4:0] s, input logic e,
                      input logic [7:0] d, input logic [2:0] p, input logic x,
                      input logic [5:0] at, input logic [3:0] mt);
    if (r < NREG)
      {rb[r], rs[r], re[r], rd[r], rp[r], rx[r], ra[r]} = {b, s, e, d, p, x, mt};
    i_rpc_core_model.idle();
    cfg_write = 1'b1;
    {cfg_reg, cfg_wdata} = {2'h0, 32'(r)};
    @(negedge clock);
    {cfg_reg, cfg_wdata} = {2'h1, b};
    @(negedge clock);
    {cfg_reg, cfg_wdata} = {2'h2, 16'h0, d, 2'h0, s, e};
    @(negedge clock);
    {cfg_reg, cfg_wdata} = {2'h3, 19'h0, x, 1'b0, p, 2'h0, at};
    @(negedge clock);
    cfg_write = 1'b0;
    @(negedge clock);
    if (r < NREG)
      check(cfg_rdata, {19'h0, x, 1'b0, p, 2'h0, at}, "readback");
  endtask : prog

  task automatic do_reset(input int n);
    resetn = 1'b0;
    for (int j = 0; j < 16; j++)
      re[j] = 1'b0;
    repeat (n) @(negedge clock);
    resetn = 1'b1;
  endtask : do_reset

  initial
  begin
    {seed, err_count, n_compared} = {32'd53, 32'd0, 32'd0};
    {cfg_write, cfg_reg, cfg_wdata, pe, bge, hve, ice, dce} = 40'h0;
    do_reset(16);
    cfg_reg = 2'h2;
    @(negedge clock);
    check(cfg_rdata, 32'h0, "size after reset");
    for (i = 0; i < 64; i++)
    begin
      r1 = $random(seed);
      {hve, ice, dce} = {i[5], r1[1:0]};
      acc({i[4:1], r1[27:0]}, i[0], r1[2] && !i[0], r1[3]);
    end
    $display("default map test done");
    prog(0, 32'h0, 5'h1f, 1'b1, 8'h00, 3'h1, 1'b0, 6'h03, 4'ha);
    prog(3, 32'h20000000, 5'h0f, 1'b1, 8'h24, 3'h3, 1'b1, 6'h02, 4'h9);
    prog(9, 32'h20004000, 5'h04, 1'b1, 8'hff, 3'h6, 1'b0, 6'h01, 4'h4);
    prog(11, 32'h40000000, 5'h07, 1'b1, 8'h01, 3'h0, 1'b0, 6'h00, 4'h0);
    prog(14, 32'h60000000, 5'h1c, 1'b1, 8'h00, 3'h3, 1'b0, 6'h00, 4'h0);
    pe = 1'b1;
    acc(32'h20000010, 1'b1, 1'b0, 1'b1);
    acc(32'h60000000, 1'b0, 1'b0, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      if (k == 1)
        prog(0, 32'h0, 5'h1f, 1'b0, 8'h00, 3'h1, 1'b0, 6'h03, 4'ha);
      for (i = 0; i < 200; i++)
      begin
        r1 = $random(seed);
        r2 = $random(seed);
        {bge, hve} = r2[9:8];
        if (r2[1:0] != 2'h3)
          r1 = BASE_T[r2[1:0]] | (r1 & MASK_T[r2[1:0]]);
        acc(r1, r2[5], r2[6] && !r2[5], r2[7]);
      end
      $display("region pass %0d done", k);
    end
    do_reset(2);
    pe = 1'b1;
    acc(32'h0, 1'b0, 1'b0, 1'b1);
    pe = 1'b0;
    i_rpc_core_model.put(32'h100, 1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clock);
    check({lock, allow}, 2'h2, "lock");
    do_reset(1);
    @(negedge clock);
    check(lock, 1'b0, "lock after reset");
    $display("lock test done");
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    close_out();
  end
endmodule : rpc_checker_tb
